/* File: wake_regs_pkg.sv */
package wake_regs_pkg;
	localparam int        FRAME_BITS    = 16;
	localparam int        HDR_BITS      = 8;
	localparam int        ADDR_W        = 7;
	localparam int        DATA_W        = 8;
	// register offsets
	localparam logic [6:0] OFS_WD_CTRL   = 7'h03;
	localparam logic [6:0] OFS_BUS_CTRL  = 7'h04;
	localparam logic [6:0] OFS_INT_WAKE  = 7'h06;
	localparam logic [6:0] OFS_EXT_WAKE  = 7'h07;
	localparam logic [6:0] OFS_BIAS      = 7'h08;
	localparam logic [6:0] OFS_FILTER    = 7'h09;
	// values after power-on or soft reset
	localparam logic [7:0] RST_WD_CTRL   = 8'h00;
	localparam logic [7:0] RST_BUS_CTRL  = 8'h20;
	localparam logic [7:0] RST_INT_WAKE  = 8'h00;
	localparam logic [7:0] RST_EXT_WAKE  = 8'h07;
	localparam logic [7:0] RST_BIAS      = 8'h00;
	localparam logic [7:0] RST_FILTER    = 8'h00;
	// implemented bits, the rest reads zero
	localparam logic [7:0] MSK_WD_CTRL   = 8'hf7;
	localparam logic [7:0] MSK_BUS_CTRL  = 8'hfb;
	localparam logic [7:0] MSK_INT_WAKE  = 8'hc4;
	localparam logic [7:0] MSK_EXT_WAKE  = 8'ha7;
	localparam logic [7:0] MSK_BIAS      = 8'h3f;
	localparam logic [7:0] MSK_FILTER    = 8'h3f;
	// bits kept over a restart
	localparam logic [7:0] KEEP_INT_WAKE = 8'hc0;
	localparam logic [7:0] KEEP_EXT_WAKE = 8'ha7;
	// fail-safe forcing
	localparam logic [4:0] FS_BUS_LOW    = 5'h09;
	localparam logic [4:0] FS_EXT_LOW    = 5'h07;
	// field positions
	localparam int        B_TMR_B_WK    = 7;
	localparam int        B_TMR_A_WK    = 6;
	localparam int        B_STOP_HI     = 2;
	localparam int        B_STOP_LO     = 6;
	localparam int        B_INT_GLOBAL  = 7;
	localparam int        B_EXT_RSVD6   = 6;
	localparam int        B_MEASURE     = 5;
	localparam int        B_CAN_LO      = 0;
	localparam int        B_LIN_LO      = 3;
	localparam logic [1:0] MODE_WAKE_CAP = 2'h1;
	// bias field codes
	localparam logic [1:0] BIAS_NONE     = 2'h0;
	localparam logic [1:0] BIAS_DOWN     = 2'h1;
	localparam logic [1:0] BIAS_UP       = 2'h2;
	localparam logic [1:0] BIAS_AUTO     = 2'h3;
endpackage : wake_regs_pkg

/* File: spi_regs_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface spi_regs_if;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic       wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic       frame_end;
	modport port (output rd_addr, input rd_data, output wr_en, output wr_addr,
		output wr_data, output frame_end);
	modport regs (input rd_addr, output rd_data, input wr_en, input wr_addr,
		input wr_data, input frame_end);
endinterface : spi_regs_if
`default_nettype wire

/* File: spi_frame_port.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_frame_port
	import wake_regs_pkg::*;
(
	input  wire logic   clock,    // system clock
	input  wire logic   rst,      // synchronous reset
	input  wire logic   sclk_pin, // serial clock pin
	input  wire logic   csn_pin,  // chip select pin, low active
	input  wire logic   mosi_pin, // serial data in
	output var  logic   sdo,      // serial data out
	spi_regs_if.port    bus       // register side
);
	typedef enum logic [1:0] {S_IDLE = 2'b01, S_SHIFT = 2'b10} st_t;
	typedef struct packed {
		logic [2:0]  sclk_s;
		logic [2:0]  csn_s;
		logic [1:0]  mosi_s;
		st_t         st;
		logic [4:0]  cnt;
		logic [15:0] rx;
		logic [7:0]  tx;
		logic        sdo;
		logic        done;
	} spi_t;
	localparam spi_t SPI_RESET = '{sclk_s: 3'h0, csn_s: 3'h7, mosi_s: 2'h0, st: S_IDLE,
		cnt: 5'h00, rx: 16'h0000, tx: 8'h00, sdo: 1'b0, done: 1'b0};
	spi_t q;
	spi_t d;
	logic rise;
	logic fall;

	assign rise          = q.sclk_s[1] & ~q.sclk_s[2];
	assign fall          = ~q.sclk_s[1] & q.sclk_s[2];
	assign bus.rd_addr   = q.rx[6:0];
	assign bus.wr_addr   = q.rx[14:8];
	assign bus.wr_data   = q.rx[7:0];
	assign bus.wr_en     = q.done & q.rx[15];
	assign bus.frame_end = q.done;
	assign sdo           = q.sdo;

	always_comb begin
		d        = q;
		d.sclk_s = {q.sclk_s[1:0], sclk_pin};
		d.csn_s  = {q.csn_s[1:0], csn_pin};
		d.mosi_s = {q.mosi_s[0], mosi_pin};
		d.done   = 1'b0;
		case (q.st)
			S_IDLE: begin
				if (!q.csn_s[1]) begin
					d.st  = S_SHIFT;
					d.cnt = 5'h00;
					d.tx  = 8'h00;
					d.sdo = 1'b0;
				end
			end
			S_SHIFT: begin
				if (q.csn_s[1]) begin
					// only whole frames count, value applied after select ends
					d.st   = S_IDLE;
					d.done = (q.cnt == 5'(FRAME_BITS));
				end else begin
					if (rise && q.cnt != 5'(FRAME_BITS)) begin
						d.rx  = {q.rx[14:0], q.mosi_s[1]};
						d.cnt = q.cnt + 5'h01;
					end
					if (fall) begin
						if (q.cnt == 5'(HDR_BITS)) begin
							d.sdo = bus.rd_data[7];
							d.tx  = {bus.rd_data[6:0], 1'b0};
						end else begin
							d.sdo = q.tx[7];
							d.tx  = {q.tx[6:0], 1'b0};
						end
					end
				end
			end
			default: d.st = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst)
			q <= SPI_RESET;
		else
			q <= d;
	end
endmodule : spi_frame_port
`default_nettype wire

/* File: wake_source_config_regs.sv */
// Operation
// - bit7 internal: second cyclic timer wakes
// - bit6 internal: first cyclic timer wakes
// - bit2 internal: stop-mode watchdog off, upper
// - bit7 external: interrupt on wakes or all status
// - measure select disables inputs one, two wake
// - measuring in normal mode, levels meaningless
// - bits2..0 external enable wake inputs three..one
// - external resets 0x07; restart clears bits 6,4,3
// - restart keeps timer enables, clears 5..0
// - fail-safe forces bus and external wake values
// - bus wakes enabled by wake-capable transceiver modes
// - bias codes: none, down, up, auto
// - bias fields 5:4,3:2,1:0, reset zero
// - reserved bits read zero, writes ignored
// - watchdog control bit6: stop-mode off, lower
// - internal register at 0x06, resets zero
`timescale 1ns/100ps
`default_nettype none
module wake_source_config_regs
	import wake_regs_pkg::*;
(
	input  wire logic       clock,           // 50 MHz system clock
	input  wire logic       rst,             // power-on or soft reset
	input  wire logic       sclk_pin,        // spi clock
	input  wire logic       csn_pin,         // spi select, low active
	input  wire logic       mosi_pin,        // spi data in
	output var  logic       sdo,             // spi data out
	input  wire logic       restart_req,     // restart pulse
	input  wire logic       failsafe_entry,  // fail-safe entry pulse
	input  wire logic       normal_mode,     // device in normal mode
	input  wire logic       stop_off_hw_clr, // hardware clears stop-off code
	input  wire logic [2:0] hv_wake_pin,     // high-voltage wake inputs
	input  wire logic       timer_a_evt,     // first cyclic timer event
	input  wire logic       timer_b_evt,     // second cyclic timer event
	input  wire logic       can_wake_evt,    // can bus wake pattern
	input  wire logic       lin_wake_evt,    // lin bus wake pattern
	input  wire logic       status_evt,      // other status bit set
	output var  logic       int_n,           // interrupt to host, low active
	output var  logic       wake_pulse,      // wake seen
	output var  logic       measure_active,  // measuring, levels 1,2 invalid
	output var  logic [2:0] hv_level,        // synced input levels
	output var  logic [1:0] hv_input3_bias,  // bias of input three
	output var  logic [1:0] hv_input2_bias,  // bias of input two
	output var  logic [1:0] hv_input1_bias,  // bias of input one
	output var  logic [5:0] filter_cfg,      // filter configuration
	output var  logic [1:0] stop_off_code,   // watchdog stop-mode code
	output var  logic [1:0] can_mode,        // can transceiver mode
	output var  logic [1:0] lin_mode         // lin transceiver mode
);
	typedef struct packed {
		logic [7:0] wd_ctl;
		logic [7:0] bus_ctl;
		logic [7:0] int_wk;
		logic [7:0] ext_wk;
		logic [7:0] bias;
		logic [7:0] filt;
		logic [2:0] wk_s1;
		logic [2:0] wk_s2;
		logic [2:0] wk_s3;
		logic       int_n;
		logic       wake;
		logic       meas;
	} regs_t;

	spi_regs_if bus ();
	regs_t q;
	regs_t d;
	logic       wake_now;
	logic [2:0] wk_edge;
	logic [2:0] wk_en_eff;
	logic       bus_wake;

	spi_frame_port u_spi (
		.clock    (clock),
		.rst      (rst),
		.sclk_pin (sclk_pin),
		.csn_pin  (csn_pin),
		.mosi_pin (mosi_pin),
		.sdo      (sdo),
		.bus      (bus.port)
	);

	function automatic logic [7:0] read_reg(input logic [6:0] a, input regs_t r);
		logic [7:0] v;
		v = 8'h00;
		if (a == OFS_WD_CTRL)
			v = r.wd_ctl;
		else if (a == OFS_BUS_CTRL)
			v = r.bus_ctl;
		else if (a == OFS_INT_WAKE)
			v = r.int_wk;
		else if (a == OFS_EXT_WAKE)
			v = r.ext_wk;
		else if (a == OFS_BIAS)
			v = r.bias;
		else if (a == OFS_FILTER)
			v = r.filt;
		return v;
	endfunction : read_reg

	function automatic logic [7:0] wr_masked(input logic [7:0] data, input logic [7:0] msk);
		return data & msk;
	endfunction : wr_masked

	assign bus.rd_data = read_reg(bus.rd_addr, q);

	// edges of the synced wake inputs and effective enables
	assign wk_edge   = q.wk_s2 ^ q.wk_s3;
	assign wk_en_eff = {q.ext_wk[2], q.ext_wk[1:0] & {2{~q.ext_wk[B_MEASURE]}}};
	assign bus_wake  = (can_wake_evt && q.bus_ctl[1:0] == MODE_WAKE_CAP)
		| (lin_wake_evt && q.bus_ctl[4:3] == MODE_WAKE_CAP);
	assign wake_now  = (timer_b_evt & q.int_wk[B_TMR_B_WK])
		| (timer_a_evt & q.int_wk[B_TMR_A_WK])
		| (|(wk_edge & wk_en_eff))
		| bus_wake;

	always_comb begin
		d       = q;
		d.wk_s1 = hv_wake_pin;
		d.wk_s2 = q.wk_s1;
		d.wk_s3 = q.wk_s2;
		d.wake  = wake_now;
		d.int_n = ~(wake_now | (q.ext_wk[B_INT_GLOBAL] & status_evt));
		d.meas  = q.ext_wk[B_MEASURE] & normal_mode;
		if (stop_off_hw_clr) begin
			d.int_wk[B_STOP_HI] = 1'b0;
			d.wd_ctl[B_STOP_LO] = 1'b0;
		end
		if (failsafe_entry) begin
			d.bus_ctl[4:0]          = FS_BUS_LOW;
			d.ext_wk[B_EXT_RSVD6]   = 1'b0;
			d.ext_wk[4:0]           = FS_EXT_LOW;
		end else if (restart_req) begin
			d.ext_wk = q.ext_wk & KEEP_EXT_WAKE;
			d.int_wk = q.int_wk & KEEP_INT_WAKE;
		end else if (bus.wr_en) begin
			// a write beats a hardware clear in the same cycle
			if (bus.wr_addr == OFS_WD_CTRL)
				d.wd_ctl = wr_masked(bus.wr_data, MSK_WD_CTRL);
			else if (bus.wr_addr == OFS_BUS_CTRL)
				d.bus_ctl = wr_masked(bus.wr_data, MSK_BUS_CTRL);
			else if (bus.wr_addr == OFS_INT_WAKE)
				d.int_wk = wr_masked(bus.wr_data, MSK_INT_WAKE);
			else if (bus.wr_addr == OFS_EXT_WAKE)
				d.ext_wk = wr_masked(bus.wr_data, MSK_EXT_WAKE);
			else if (bus.wr_addr == OFS_BIAS)
				d.bias = wr_masked(bus.wr_data, MSK_BIAS);
			else if (bus.wr_addr == OFS_FILTER)
				d.filt = wr_masked(bus.wr_data, MSK_FILTER);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q.wd_ctl  <= RST_WD_CTRL;
			q.bus_ctl <= RST_BUS_CTRL;
			q.int_wk  <= RST_INT_WAKE;
			q.ext_wk  <= RST_EXT_WAKE;
			q.bias    <= RST_BIAS;
			q.filt    <= RST_FILTER;
			q.wk_s1   <= 3'h0;
			q.wk_s2   <= 3'h0;
			q.wk_s3   <= 3'h0;
			q.int_n   <= 1'b1;
			q.wake    <= 1'b0;
			q.meas    <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign int_n          = q.int_n;
	assign wake_pulse     = q.wake;
	assign measure_active = q.meas;
	assign hv_level       = q.wk_s2;
	assign hv_input3_bias = q.bias[5:4];
	assign hv_input2_bias = q.bias[3:2];
	assign hv_input1_bias = q.bias[1:0];
	assign filter_cfg     = q.filt[5:0];
	assign stop_off_code  = {q.int_wk[B_STOP_HI], q.wd_ctl[B_STOP_LO]};
	assign can_mode       = q.bus_ctl[1:0];
	assign lin_mode       = q.bus_ctl[4:3];

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_restart_ext_keep: assert property (
		restart_req && !failsafe_entry |=> q.ext_wk == ($past(q.ext_wk) & 8'ha7))
		else $error("external wake register wrong after restart");

	a_restart_int_keep: assert property (
		restart_req && !failsafe_entry |=> q.int_wk[5:0] == 6'h00
			&& q.int_wk[7:6] == $past(q.int_wk[7:6]))
		else $error("internal wake register wrong after restart");

	a_failsafe_force: assert property (
		failsafe_entry |=> q.bus_ctl[4:0] == 5'h09 && q.ext_wk[6] == 1'b0
			&& q.ext_wk[4:0] == 5'h07 && q.ext_wk[7] == $past(q.ext_wk[7]))
		else $error("fail-safe values not forced");

	a_reserved_zero: assert property (
		(q.ext_wk & 8'h58) == 8'h00 && (q.int_wk & 8'h3b) == 8'h00
			&& (q.bias & 8'hc0) == 8'h00 && q.bus_ctl[2] == 1'b0)
		else $error("reserved bit set");

	a_timer_b_wake: assert property (
		timer_b_evt && q.int_wk[7] |=> wake_pulse && !int_n)
		else $error("second timer wake missed");

	a_timer_a_wake: assert property (
		timer_a_evt && q.int_wk[6] |=> wake_pulse ##0 !int_n)
		else $error("first timer wake missed");

	a_int_scope_only: assert property (
		!wake_now && !(q.ext_wk[7] && status_evt) |=> int_n)
		else $error("interrupt without cause");

	a_frame_commit: assert property (
		$changed(q.ext_wk) |-> $past(bus.frame_end || restart_req || failsafe_entry))
		else $error("external register changed outside frame end");

	a_bias_reset_zero: assert property (
		$past(rst) |-> q.bias == 8'h00 && q.int_wk == 8'h00 && q.ext_wk == 8'h07)
		else $error("wrong value after reset");

	a_measure_block: assert property (
		q.ext_wk[5] && !timer_a_evt && !timer_b_evt && !bus_wake && !wk_edge[2]
			|=> !wake_pulse)
		else $error("wake from measured input");
endmodule : wake_source_config_regs
`default_nettype wire

/* File: host_spi.sv */
`timescale 1ns/100ps
`default_nettype none
module host_spi (
	input  wire logic clock, // system clock
	input  wire logic sdo,   // device data out
	output var  logic sclk,  // serial clock, idle low
	output var  logic csn,   // select, low active
	output var  logic mosi   // serial data to device
);
	initial begin
		sclk = 1'b0;
		csn  = 1'b1;
		mosi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	// n bits msb first; fewer than 16 makes a frame the device must drop
	task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		csn = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			mosi = tx[i];
			tick(4);
			sclk = 1'b1;
			if (i < 8) rx[i] = sdo;
			tick(4);
			sclk = 1'b0;
		end
		tick(4);
		csn = 1'b1;
		// released line must not keep the last bit
		mosi = ~mosi;
		tick(8);
	endtask : xfer
endmodule : host_spi
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import wake_regs_pkg::*;
	logic       clock, rst, sclk, csn, mosi, sdo, restart_req, failsafe_entry;
	logic       normal_mode, hw_clr, int_n, wake_pulse, measure_active;
	logic [2:0] pins, hv_level;
	logic [4:0] ev;
	logic [1:0] b3, b2, b1, stop_code, can_mode, lin_mode;
	logic [5:0] filter_cfg;
	int         num_errors, checked, cycles;

	host_spi host (.clock(clock), .sdo(sdo), .sclk(sclk), .csn(csn), .mosi(mosi));
	wake_source_config_regs dut (.clock(clock), .rst(rst), .sclk_pin(sclk), .csn_pin(csn),
		.mosi_pin(mosi), .sdo(sdo), .restart_req(restart_req),
		.failsafe_entry(failsafe_entry), .normal_mode(normal_mode), .stop_off_hw_clr(hw_clr),
		.hv_wake_pin(pins), .timer_a_evt(ev[0]), .timer_b_evt(ev[1]), .can_wake_evt(ev[2]),
		.lin_wake_evt(ev[3]), .status_evt(ev[4]), .int_n(int_n), .wake_pulse(wake_pulse),
		.measure_active(measure_active), .hv_level(hv_level), .hv_input3_bias(b3),
		.hv_input2_bias(b2), .hv_input1_bias(b1), .filter_cfg(filter_cfg),
		.stop_off_code(stop_code), .can_mode(can_mode), .lin_mode(lin_mode));

	always #10 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic close_out();
		if (num_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		host.xfer({1'b1, a, d}, 16, r);
	endtask : wr
	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] r;
		host.xfer({1'b0, a, 8'h00}, 16, r);
		chk($sformatf("register %h", a), exp, r);
	endtask : rdc
	// one-cycle event, answer expected one cycle later
	task automatic fire(input logic [4:0] m, input logic wk, input logic irq);
		ev = m;
		host.tick(1);
		ev = 5'h00;
		chk("wake_pulse", {7'h00, wk}, {7'h00, wake_pulse});
		chk("int_n", {7'h00, ~irq}, {7'h00, int_n});
	endtask : fire
	task automatic pin(input int k, input logic wk);
		logic seen;
		seen = 1'b0;
		pins[k] = ~pins[k];
		repeat (8) begin
			host.tick(1);
			seen = seen | wake_pulse;
		end
		chk($sformatf("pin %0d wake", k), {7'h00, wk}, {7'h00, seen});
		chk($sformatf("pin %0d level", k), {7'h00, pins[k]}, {7'h00, hv_level[k]});
	endtask : pin
	task automatic pulse_restart();
		restart_req = 1'b1;
		host.tick(1);
		restart_req = 1'b0;
		host.tick(1);
	endtask : pulse_restart

	task automatic t_reset();
		rdc(OFS_INT_WAKE, 8'h00);
		rdc(OFS_EXT_WAKE, 8'h07);
		rdc(OFS_BIAS, 8'h00);
		chk("bias outputs", 8'h00, {2'b00, b3, b2, b1});
	endtask : t_reset
	task automatic t_masks();
		wr(OFS_INT_WAKE, 8'hff);
		rdc(OFS_INT_WAKE, 8'hc4);
		wr(OFS_EXT_WAKE, 8'hff);
		rdc(OFS_EXT_WAKE, 8'ha7);
		wr(OFS_BIAS, 8'hff);
		rdc(OFS_BIAS, 8'h3f);
		wr(OFS_FILTER, 8'hff);
		rdc(OFS_FILTER, 8'h3f);
		chk("filter_cfg", 8'h3f, {2'b00, filter_cfg});
		wr(OFS_FILTER, 8'h15);
		chk("filter_cfg", 8'h15, {2'b00, filter_cfg});
		wr(7'h7f, 8'hff);
		rdc(7'h7f, 8'h00);
	endtask : t_masks
	task automatic t_bias();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(OFS_BIAS, {2'b00, c, c + 2'h1, c + 2'h2});
			chk("bias fields", {2'b00, c, c + 2'h1, c + 2'h2}, {2'b00, b3, b2, b1});
		end
	endtask : t_bias
	task automatic t_timer();
		wr(OFS_INT_WAKE, 8'h00);
		fire(5'h01, 1'b0, 1'b0);
		fire(5'h02, 1'b0, 1'b0);
		wr(OFS_INT_WAKE, 8'h40);
		fire(5'h01, 1'b1, 1'b1);
		fire(5'h02, 1'b0, 1'b0);
		wr(OFS_INT_WAKE, 8'h80);
		fire(5'h02, 1'b1, 1'b1);
	endtask : t_timer
	task automatic t_stop();
		wr(OFS_WD_CTRL, 8'h00);
		wr(OFS_INT_WAKE, 8'h04);
		chk("stop code", 8'h02, {6'h00, stop_code});
		wr(OFS_WD_CTRL, 8'h40);
		chk("stop code", 8'h03, {6'h00, stop_code});
		hw_clr = 1'b1;
		host.tick(1);
		hw_clr = 1'b0;
		host.tick(1);
		chk("stop code", 8'h00, {6'h00, stop_code});
	endtask : t_stop
	task automatic t_scope();
		wr(OFS_EXT_WAKE, 8'h07);
		fire(5'h10, 1'b0, 1'b0);
		wr(OFS_EXT_WAKE, 8'h87);
		fire(5'h10, 1'b0, 1'b1);
	endtask : t_scope
	task automatic t_meas();
		normal_mode = 1'b1;
		wr(OFS_EXT_WAKE, 8'h27);
		chk("measure_active", 8'h01, {7'h00, measure_active});
		normal_mode = 1'b0;
		host.tick(1);
		chk("measure_active", 8'h00, {7'h00, measure_active});
		normal_mode = 1'b1;
		host.tick(1);
		chk("measure_active", 8'h01, {7'h00, measure_active});
		pin(0, 1'b0);
		pin(1, 1'b0);
		pin(2, 1'b1);
		wr(OFS_EXT_WAKE, 8'h03);
		chk("measure_active", 8'h00, {7'h00, measure_active});
		pin(2, 1'b0);
		pin(0, 1'b1);
		pin(1, 1'b1);
	endtask : t_meas
	task automatic t_restart();
		wr(OFS_INT_WAKE, 8'hc4);
		wr(OFS_EXT_WAKE, 8'ha7);
		pulse_restart();
		rdc(OFS_INT_WAKE, 8'hc0);
		rdc(OFS_EXT_WAKE, 8'ha7);
	endtask : t_restart
	task automatic t_fail();
		wr(OFS_BUS_CTRL, 8'h00);
		wr(OFS_EXT_WAKE, 8'h80);
		failsafe_entry = 1'b1;
		host.tick(1);
		failsafe_entry = 1'b0;
		host.tick(1);
		rdc(OFS_BUS_CTRL, 8'h09);
		rdc(OFS_EXT_WAKE, 8'h87);
		chk("bus modes", 8'h05, {4'h0, lin_mode, can_mode});
		fire(5'h04, 1'b1, 1'b1);
		fire(5'h08, 1'b1, 1'b1);
		wr(OFS_BUS_CTRL, 8'h00);
		fire(5'h04, 1'b0, 1'b0);
	endtask : t_fail
	task automatic t_short();
		logic [7:0] r;
		wr(OFS_BIAS, 8'h00);
		host.xfer({1'b1, OFS_BIAS, 8'h3f}, 12, r);
		rdc(OFS_BIAS, 8'h00);
	endtask : t_short

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		restart_req = 1'b0;
		failsafe_entry = 1'b0;
		normal_mode = 1'b0;
		hw_clr = 1'b0;
		pins = 3'h0;
		ev = 5'h00;
		host.tick(2);
		rst = 1'b0;
		host.tick(4);
		t_reset();
		t_masks();
		t_bias();
		t_timer();
		t_stop();
		t_scope();
		t_meas();
		t_restart();
		t_fail();
		t_short();
		close_out();
	end
endmodule : tb_top
`default_nettype wire
